// ---- rtl/otp_region_defines.vh ----
// constants for the security-region command block
// assumes a 125 MHz system clock sampling a slower serial link
`ifndef OTP_REGION_DEFINES_VH
`define OTP_REGION_DEFINES_VH
`define OP_PROGRAM 8'h9B
`define OP_READ 8'h77
`define OP_STATUS 8'h05
`define OP_WREN 8'h06
`define USER_BYTES 7'h40
`define REGION_AW 7
`define ERASED_BYTE 8'hFF
`define STAT_BUSY_BIT 0
`define STAT_WEL_BIT 1
`define PROG_TIME_US 500
`define CLK_MHZ 125
`define PROG_CYCLES (`PROG_TIME_US * `CLK_MHZ)
`define FIFO_DEPTH 4
`endif

// ---- rtl/byte_fifo.v ----
// small FIFO with valid and ready on both sides
// assumes one clock for writer and reader
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire i_clock,
    input wire i_rst_b,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0] wp_q;
    reg [AW-1:0] rp_q;
    reg [AW:0] cnt_q;
    wire push = i_in_valid && o_in_ready;
    wire pop = o_out_valid && i_out_ready;
    assign o_in_ready = (cnt_q != DEPTH[AW:0]);
    assign o_out_valid = (cnt_q != {(AW+1){1'b0}});
    assign o_out_data = mem_q[rp_q];
    always @(posedge i_clock)
    begin
        if (push)
        begin
            mem_q[wp_q] <= i_in_data;
        end
    end
    always @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            wp_q <= {AW{1'b0}};
            rp_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
            begin
                wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
            end
            if (pop)
            begin
                rp_q <= (rp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
            end
            if (push && !pop)
            begin
                cnt_q <= cnt_q + 1'b1;
            end
            else if (pop && !push)
            begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- rtl/otp_region_access.v ----
// serial command slave for a 128-byte one-time-programmable security region
// assumes mode 0 serial link, all pins asynchronous to i_clock and slower than it
`timescale 1ns/1ps
`default_nettype none
`include "otp_region_defines.vh"
module otp_region_access #(
    parameter PROG_CYCLES = `PROG_CYCLES,
    parameter [511:0] SERIAL_NUMBER = {64{8'h5A}} // arbitrary value
) (
    input wire i_clock,
    input wire i_rst_b,
    input wire i_cs_b,
    input wire i_sck,
    input wire i_mosi,
    input wire i_used_flag,
    output reg o_miso,
    output reg o_miso_oe,
    output reg o_used_set,
    output reg o_busy
);
    // ***********************************
    // pin synchronisers
    // ***********************************
    reg cs_m_q, cs_s_q, sck_m_q, sck_s_q, sck_p_q, mosi_m_q, mosi_s_q;
    always @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            cs_m_q <= 1'b1;
            cs_s_q <= 1'b1;
            sck_m_q <= 1'b0;
            sck_s_q <= 1'b0;
            sck_p_q <= 1'b0;
            mosi_m_q <= 1'b0;
            mosi_s_q <= 1'b0;
        end
        else
        begin
            cs_m_q <= i_cs_b;
            cs_s_q <= cs_m_q;
            sck_m_q <= i_sck;
            sck_s_q <= sck_m_q;
            sck_p_q <= sck_s_q;
            mosi_m_q <= i_mosi;
            mosi_s_q <= mosi_m_q;
        end
    end
    wire active = !cs_s_q;
    wire rise = active && sck_s_q && !sck_p_q;
    wire fall = active && !sck_s_q && sck_p_q;
    reg cs_p_q;
    always @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            cs_p_q <= 1'b1;
        end
        else
        begin
            cs_p_q <= cs_s_q;
        end
    end
    wire release_ev = cs_s_q && !cs_p_q;

    // ***********************************
    // storage
    // ***********************************
    // factory half is a constant: no write path can reach it
    // user half is read flat so both read paths share one byte select
    wire [511:0] user_flat;
    reg [7:0] buf_q [0:63];
    reg [63:0] sent_q;

    // ***********************************
    // command shifter
    // ***********************************
    localparam ST_OP = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_DATA = 3'd2;
    localparam ST_DUMMY = 3'd3;
    localparam ST_OUT = 3'd4;
    localparam ST_STAT = 3'd5;
    localparam ST_IGNORE = 3'd6;
    reg [2:0] state_q;
    reg [2:0] bitc_q;
    reg [7:0] sh_q;
    reg [7:0] op_q;
    reg [1:0] bytec_q;
    reg [6:0] addr_q;
    reg [6:0] ndata_q;
    reg [7:0] obuf_q;
    reg wel_q;
    wire [7:0] inbyte = {sh_q[6:0], mosi_s_q};
    wire byte_done = rise && (bitc_q == 3'd7);
    reg [7:0] status;
    always @*
    begin
        status = 8'h00;
        status[`STAT_BUSY_BIT] = o_busy;
        status[`STAT_WEL_BIT] = wel_q;
    end
    wire [6:0] rd_next = addr_q + 7'h01;
    wire [7:0] rd_byte = addr_q[6] ? SERIAL_NUMBER[{addr_q[5:0], 3'b000} +: 8] :
        user_flat[{addr_q[5:0], 3'b000} +: 8];
    // next byte picks its half from the next address, so 3Fh and 7Fh switch source
    wire [7:0] rd_next_byte = rd_next[6] ? SERIAL_NUMBER[{rd_next[5:0], 3'b000} +: 8] :
        user_flat[{rd_next[5:0], 3'b000} +: 8];

    // ***********************************
    // data buffer
    // ***********************************
    // data captured into a FIFO so the program engine never races the shifter
    wire fifo_in_ready, fifo_out_valid;
    wire [7:0] fifo_out_data;
    reg fifo_push;
    byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH), .AW(2)) u_fifo (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_in_valid(fifo_push),
        .o_in_ready(fifo_in_ready),
        .i_in_data(inbyte),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(1'b1),
        .o_out_data(fifo_out_data)
    );
    reg [5:0] fifo_wptr_q;
    reg drain_pending;
    always @*
    begin
        fifo_push = byte_done && (state_q == ST_DATA) && fifo_in_ready;
        drain_pending = fifo_out_valid;
    end

    // ***********************************
    // command decode and program engine
    // ***********************************
    // busy starts at the release itself so a poll right after it never sees ready
    reg [31:0] prog_cnt_q;
    reg prog_pend_q;
    wire prog_fire = prog_pend_q && !drain_pending;
    always @(posedge i_clock)
    begin
        if (!i_rst_b)
        begin
            state_q <= ST_OP;
            bitc_q <= 3'd0;
            sh_q <= 8'h00;
            op_q <= 8'h00;
            bytec_q <= 2'd0;
            addr_q <= 7'h00;
            ndata_q <= 7'h00;
            obuf_q <= 8'h00;
            wel_q <= 1'b0;
            o_miso <= 1'b0;
            o_miso_oe <= 1'b0;
            o_used_set <= 1'b0;
            o_busy <= 1'b0;
            prog_cnt_q <= 32'h0000_0000;
            prog_pend_q <= 1'b0;
            fifo_wptr_q <= 6'h00;
            sent_q <= 64'h0000_0000_0000_0000;
        end
        else
        begin
            o_used_set <= 1'b0;
            if (fifo_out_valid)
            begin
                buf_q[fifo_wptr_q] <= fifo_out_data;
                sent_q[fifo_wptr_q] <= 1'b1;
                fifo_wptr_q <= fifo_wptr_q + 6'h01;
            end
            if (rise)
            begin
                sh_q <= inbyte;
                bitc_q <= bitc_q + 3'd1;
            end
            if (byte_done)
            begin
                case (state_q)
                    ST_OP:
                    begin
                        op_q <= inbyte;
                        bytec_q <= 2'd0;
                        if (o_busy && inbyte != `OP_STATUS)
                        begin
                            state_q <= ST_IGNORE;
                        end
                        else if (inbyte == `OP_WREN)
                        begin
                            wel_q <= 1'b1;
                            state_q <= ST_IGNORE;
                        end
                        else if (inbyte == `OP_STATUS)
                        begin
                            obuf_q <= status;
                            state_q <= ST_STAT;
                        end
                        else if (inbyte == `OP_PROGRAM || inbyte == `OP_READ)
                        begin
                            state_q <= ST_ADDR;
                        end
                        else
                        begin
                            state_q <= ST_IGNORE;
                        end
                    end
                    ST_ADDR:
                    begin
                        bytec_q <= bytec_q + 2'd1;
                        if (bytec_q == 2'd2)
                        begin
                            addr_q <= inbyte[6:0];
                            fifo_wptr_q <= inbyte[5:0];
                            ndata_q <= 7'h00;
                            sent_q <= 64'h0000_0000_0000_0000;
                            bytec_q <= 2'd0;
                            state_q <= (op_q == `OP_PROGRAM) ? ST_DATA : ST_DUMMY;
                        end
                    end
                    ST_DATA:
                    begin
                        if (ndata_q != `USER_BYTES)
                        begin
                            ndata_q <= ndata_q + 7'h01;
                        end
                    end
                    ST_DUMMY:
                    begin
                        bytec_q <= bytec_q + 2'd1;
                        if (bytec_q == 2'd1)
                        begin
                            obuf_q <= rd_byte;
                            state_q <= ST_OUT;
                        end
                    end
                    ST_OUT:
                    begin
                        addr_q <= rd_next;
                        obuf_q <= rd_next_byte;
                    end
                    ST_STAT:
                    begin
                        obuf_q <= status;
                    end
                    default:
                    begin
                        state_q <= ST_IGNORE;
                    end
                endcase
            end
            // shift out on falling edges, msb first
            if (fall && (state_q == ST_OUT || state_q == ST_STAT))
            begin
                o_miso_oe <= 1'b1;
                o_miso <= obuf_q[3'd7 - bitc_q];
            end
            if (release_ev)
            begin
                o_miso_oe <= 1'b0;
                state_q <= ST_OP;
                bitc_q <= 3'd0;
                if (op_q == `OP_PROGRAM && !o_busy)
                begin
                    wel_q <= 1'b0;
                    if (wel_q && !i_used_flag && state_q == ST_DATA && ndata_q != 7'h00 &&
                        bitc_q == 3'd0)
                    begin
                        o_used_set <= 1'b1;
                        o_busy <= 1'b1;
                        prog_pend_q <= 1'b1;
                        prog_cnt_q <= PROG_CYCLES;
                    end
                end
                op_q <= 8'h00;
            end
            if (prog_fire)
            begin
                // self-timed; no suspend path exists
                prog_pend_q <= 1'b0;
            end
            if (o_busy && !prog_pend_q)
            begin
                if (prog_cnt_q <= 32'h0000_0001)
                begin
                    o_busy <= 1'b0;
                end
                else
                begin
                    prog_cnt_q <= prog_cnt_q - 32'h0000_0001;
                end
            end
        end
    end

    // ***********************************
    // one-time cells of the user half
    // ***********************************
    // no reset: the cells stand for nonvolatile storage and start erased
    genvar g;
    generate
        for (g = 0; g < 64; g = g + 1)
        begin : g_cell
            reg [7:0] cell_q;
            initial
            begin
                cell_q = `ERASED_BYTE;
            end
            always @(posedge i_clock)
            begin
                if (prog_fire)
                begin
                    cell_q <= sent_q[g] ? buf_q[g] : `ERASED_BYTE;
                end
            end
            assign user_flat[8 * g +: 8] = cell_q;
        end
    endgenerate
endmodule
`default_nettype wire

// ---- dv/otp_region_monitor.sv ----
// port checker for the security-region command block
// assumes it is bound to otp_region_access and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module otp_region_monitor #(
    parameter PROG_CYCLES = 50
) (
    input wire logic i_clock,
    input wire logic i_rst_b,
    input wire logic i_cs_b,
    input wire logic i_sck,
    input wire logic i_mosi,
    input wire logic i_used_flag,
    input wire logic o_miso,
    input wire logic o_miso_oe,
    input wire logic o_used_set,
    input wire logic o_busy
);
    // ****************************************
    // busy length, slack of two for launch edges
    // ****************************************
    logic [31:0] busy_cnt_q;
    always_ff @(posedge i_clock)
    begin
        if (!i_rst_b || !o_busy)
            busy_cnt_q <= 32'h0000_0000;
        else
            busy_cnt_q <= busy_cnt_q + 32'h0000_0001;
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    property p_oe_off;
        i_cs_b [*6] |-> !o_miso_oe;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("data out driven while deselected");
    property p_used_fresh;
        o_used_set |-> !i_used_flag;
    endproperty
    a_used_fresh: assert property (p_used_fresh)
        else $error("used region programmed again");
    property p_set_after_cs;
        o_used_set |-> i_cs_b && $past(i_cs_b);
    endproperty
    a_set_after_cs: assert property (p_set_after_cs)
        else $error("program started before release");
    property p_set_pulse;
        o_used_set |=> !o_used_set;
    endproperty
    a_set_pulse: assert property (p_set_pulse)
        else $error("used set longer than one cycle");
    property p_busy_follows;
        o_used_set |-> ##[0:3] o_busy;
    endproperty
    a_busy_follows: assert property (p_busy_follows)
        else $error("no busy after program start");
    property p_busy_cause;
        $rose(o_busy) |-> o_used_set || $past(o_used_set) || $past(o_used_set, 2)
            || $past(o_used_set, 3);
    endproperty
    a_busy_cause: assert property (p_busy_cause)
        else $error("busy without marking region used");
    property p_busy_cs;
        $rose(o_busy) |-> i_cs_b;
    endproperty
    a_busy_cs: assert property (p_busy_cs)
        else $error("busy raised while selected");
    property p_busy_len;
        busy_cnt_q <= PROG_CYCLES + 2;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("program time exceeded");
endmodule
bind otp_region_access otp_region_monitor #(.PROG_CYCLES(PROG_CYCLES)) mon (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_cs_b(i_cs_b), .i_sck(i_sck),
    .i_mosi(i_mosi), .i_used_flag(i_used_flag), .o_miso(o_miso),
    .o_miso_oe(o_miso_oe), .o_used_set(o_used_set), .o_busy(o_busy));
`default_nettype wire

// ---- dv/spi_host_model.sv ----
// serial host model: chip select, link clock and data in
// assumes the 8 ns bench clock; one link bit lasts ten of its cycles
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input wire logic i_clock,
    input wire logic i_miso,
    output logic o_cs_b,
    output logic o_sck,
    output logic o_mosi
);
    initial
    begin
        o_cs_b = 1'b1;
        o_sck = 1'b0;
        o_mosi = 1'b0;
    end
    task automatic cs_on();
        @(posedge i_clock);
        o_cs_b <= 1'b0;
        repeat (5) @(posedge i_clock);
    endtask
    // msb first; data set while the clock is low, both sides sample at its rise
    task automatic shift(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < nbits; i++)
        begin
            o_mosi <= tx[7 - i];
            repeat (5) @(posedge i_clock);
            o_sck <= 1'b1;
            rx = {rx[6:0], i_miso};
            repeat (5) @(posedge i_clock);
            o_sck <= 1'b0;
        end
    endtask
    // data in flips on release so a stale bit never passes for a fresh one
    task automatic cs_off();
        repeat (5) @(posedge i_clock);
        o_cs_b <= 1'b1;
        o_mosi <= ~o_mosi;
        repeat (10) @(posedge i_clock);
    endtask
endmodule
`default_nettype wire

// ---- dv/tb_top.sv ----
// self-checking bench for the security-region command block
// assumes the host model and the bound checker; 125 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic i_clock;
    logic i_rst_b;
    logic used_flag_q;
    wire logic cs_b, sck, mosi, miso, miso_oe, used_set, busy, miso_w;
    int fails;
    int cmp_count;
    int nset;
    logic [7:0] rx;
    logic [7:0] exp_mem [0:127];
    assign miso_w = miso_oe ? miso : 1'bz;
    otp_region_access #(.PROG_CYCLES(2000), .SERIAL_NUMBER({64{8'hA5}})) dut (
        .i_clock(i_clock), .i_rst_b(i_rst_b), .i_cs_b(cs_b), .i_sck(sck),
        .i_mosi(mosi), .i_used_flag(used_flag_q), .o_miso(miso),
        .o_miso_oe(miso_oe), .o_used_set(used_set), .o_busy(busy));
    spi_host_model host (.i_clock(i_clock), .i_miso(miso_w), .o_cs_b(cs_b),
        .o_sck(sck), .o_mosi(mosi));
    initial
    begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end
    // nonvolatile flag: survives reset, set only by the pulse
    always @(posedge i_clock)
    begin
        if (used_set === 1'b1)
        begin
            used_flag_q <= 1'b1;
            nset <= nset + 1;
        end
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask
    task automatic send(input logic [7:0] b);
        host.shift(b, 8, rx);
    endtask
    task automatic status(output logic [7:0] s);
        host.cs_on();
        send(8'h05);
        host.shift(8'h00, 8, s);
        host.cs_off();
    endtask
    task automatic wren();
        host.cs_on();
        send(8'h06);
        host.cs_off();
    endtask
    // upper address bits set on purpose; last gives the bits of the final byte
    task automatic prog(input logic [7:0] a, input int n, input int last);
        host.cs_on();
        send(8'h9B);
        send(8'hFF);
        send(8'hC0);
        send(a | 8'hC0);
        for (int i = 0; i < n; i++)
            host.shift(8'hC1 + i[7:0], (i == n - 1) ? last : 8, rx);
        host.cs_off();
    endtask
    // whole region from a, then a half byte to release mid-byte
    task automatic check_region(input logic [7:0] a);
        logic [7:0] hdr [6] = '{8'h77, 8'h00, 8'h00, a, 8'h00, 8'h00};
        host.cs_on();
        foreach (hdr[i])
            send(hdr[i]);
        for (int i = 0; i < 128; i++)
        begin
            send(8'h00);
            chk(rx, exp_mem[(a + i) % 128]);
        end
        host.shift(8'h00, 4, rx);
        host.cs_off();
        chk({7'h00, miso_oe}, 8'h00);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_idle();
        logic [7:0] s;
        chk({6'h00, busy, miso_oe}, 8'h00);
        status(s);
        chk(s & 8'h03, 8'h00);
        wren();
        status(s);
        chk(s & 8'h03, 8'h02);
    endtask
    task automatic t_aborts();
        logic [7:0] s;
        prog(8'h00, 0, 8);
        status(s);
        chk({s[1:0], nset[5:0]}, 8'h00);
        wren();
        prog(8'h00, 1, 4);
        status(s);
        chk({s[1:0], nset[5:0]}, 8'h00);
        prog(8'h00, 1, 8);
        chk(nset[7:0], 8'h00);
    endtask
    task automatic t_program();
        logic [7:0] s;
        int k;
        wren();
        prog(8'h3E, 3, 8);
        exp_mem[62] = 8'hC1;
        exp_mem[63] = 8'hC2;
        exp_mem[0] = 8'hC3;
        status(s);
        chk({s[0], nset[6:0]}, 8'h81);
        k = 0;
        while (s[0] !== 1'b0 && k < 40)
        begin
            status(s);
            k++;
        end
        if (s[0] !== 1'b0)
        begin
            fails++;
            final_report();
        end
        chk(s & 8'h03, 8'h00);
        check_region(8'h00);
    endtask
    task automatic t_again();
        logic [7:0] s;
        wren();
        prog(8'h00, 2, 8);
        status(s);
        chk({s[1:0], nset[5:0]}, 8'h01);
        check_region(8'h40);
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        fails = 0;
        cmp_count = 0;
        nset = 0;
        used_flag_q = 1'b0;
        i_rst_b = 1'b0;
        for (int i = 0; i < 128; i++)
            exp_mem[i] = (i < 64) ? 8'hFF : 8'hA5;
        repeat (10) @(posedge i_clock);
        i_rst_b <= 1'b1;
        repeat (4) @(posedge i_clock);
        t_idle();
        check_region(8'h40);
        t_aborts();
        t_program();
        t_again();
        final_report();
    end
endmodule
`default_nettype wire
